// ==== bench/sis_chk.sv ====
// port assertions for the system interrupt stage
`timescale 1ns/1ps
`default_nettype none
module sis_chk #(parameter int unsigned NUM_SRC = 32, parameter int unsigned NUM_EVT = 9) (
  input wire logic clk_sys, resetn, core_idle, reg_sel, reg_wr, reg_supervisor, wake_core,
  input wire logic [NUM_SRC-1:0] periph_irq,
  input wire logic [NUM_EVT-1:0] active_event_register, latched_event_register, shared_event,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata, reg_rdata
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // mask write, one idle cycle, mask read
  sequence wr_m; reg_sel && reg_wr && reg_supervisor && reg_addr == 4'h0; endsequence
  sequence rd_m; reg_sel && !reg_wr && reg_supervisor && reg_addr == 4'h0; endsequence
  a_mask_readback: assert property (
    wr_m ##1 !reg_sel ##1 rd_m |=> reg_rdata == $past(reg_wdata, 3)) else $error("mask");
  a_user_read: assert property (
    reg_sel && !reg_wr && !reg_supervisor |=> reg_rdata == 0) else $error("user read");
  a_unmapped_read: assert property (
    reg_sel && !reg_wr && reg_addr[1:0] != 0 |=> reg_rdata == 0) else $error("unmapped");
  a_wake_idle: assert property (wake_core |-> $past(core_idle)) else $error("wake");
  a_shared_quiet: assert property (
    (periph_irq == 0) [*8] |=> shared_event == 0) else $error("shared");
  a_latch_edge: assert property (
    $rose(latched_event_register[0]) |-> $past(shared_event[0], 3)) else $error("latch");
  a_latch_clear: assert property (
    $rose(active_event_register[0]) |-> !latched_event_register[0]) else $error("clear");
  a_min_latency: assert property (
    $rose(shared_event[0]) && active_event_register == 0 && latched_event_register == 0
    |-> (!active_event_register[0]) [*3]) else $error("latency");
endmodule : sis_chk
bind sis_system_stage sis_chk #(.NUM_SRC(NUM_SRC), .NUM_EVT(NUM_EVT)) sis_chk_i (.*);
`default_nettype wire

// ==== bench/sis_seq.sv ====
// core sequencer model: admits every event and returns from it at once
`timescale 1ns/1ps
`default_nettype none
module sis_seq (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic [8:0] active_event_register,
  output logic      [8:0] core_enter_ok,
  output logic      [8:0] core_event_done
);
  assign core_enter_ok = 9'h1FF;
  // a return pulse every other cycle while an event reads active keeps nesting shallow
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) core_event_done <= 9'h000;
    else core_event_done <= active_event_register & ~core_event_done;
  end
endmodule : sis_seq
`default_nettype wire

// ==== bench/sis_system_stage_tb.sv ====
// self-checking bench for the system interrupt stage
`timescale 1ns/1ps
`default_nettype none
module sis_system_stage_tb;
  logic clk_sys = 0, resetn = 0, core_idle = 0, reg_sel = 0, reg_wr = 0, reg_supervisor = 0;
  logic [31:0] periph_irq = '0, reg_wdata = '0, reg_rdata;
  logic [8:0] core_enter_ok, core_event_done, active_event_register, latched_event_register;
  logic [8:0] shared_event;
  logic [3:0] reg_addr = '0;
  logic wake_core;
  int miscompares = 0, check_count = 0, n;
  always #25 clk_sys = ~clk_sys;
  sis_system_stage sis_system_stage_i (.*);
  sis_seq sis_seq_i (.*);
  task chk(input logic [31:0] g, e);
    check_count++;
    if (g !== e) miscompares++;
    if (g !== e) $display("[FAIL] %0t got %h exp %h", $time, g, e);
  endtask : chk
  // read data stands in the cycle after the request edge
  task acc(input logic w, s, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {reg_sel, reg_wr, reg_supervisor, reg_addr, reg_wdata} <= {1'b1, w, s, a, d};
    @(posedge clk_sys) reg_sel <= 1'b0;
    @(negedge clk_sys);
  endtask : acc
  task t_regs;
    acc(1, 0, 4'h0, 32'hFFFF_FFFF);
    acc(0, 1, 4'h0, '0);
    chk(reg_rdata, sis_pkg::RST_MASK);
    acc(1, 1, 4'h0, 32'h8000_0008);
    acc(0, 1, 4'h0, '0);
    chk(reg_rdata, 32'h8000_0008);
    acc(0, 0, 4'h6, '0);
    chk(reg_rdata, '0);
  endtask : t_regs
  task t_event;
    @(posedge clk_sys) periph_irq <= 32'h20;
    repeat (8) @(negedge clk_sys);
    acc(0, 1, 4'h4, '0);
    chk(reg_rdata, 32'h20);
    chk(shared_event, '0);
    repeat (2) begin
      @(posedge clk_sys) periph_irq <= 32'h28;
      for (n = 0; n < 20 && active_event_register[0] !== 1'b1; n++) @(negedge clk_sys);
      chk({shared_event[0], active_event_register[0]}, 2'h3);
      @(posedge clk_sys) periph_irq <= 32'h20;
      repeat (12) @(negedge clk_sys);
    end
  endtask : t_event
  task t_wake;
    acc(1, 1, 4'h8, 32'h20);
    @(posedge clk_sys) core_idle <= 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(wake_core, 1'b1);
    @(posedge clk_sys) core_idle <= 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(wake_core, 1'b0);
  endtask : t_wake
  task summarize;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    t_regs;
    t_event;
    t_wake;
    summarize;
  end
  // the tests need about a hundred cycles
  initial begin
    #100us;
    miscompares++;
    summarize;
  end
endmodule : sis_system_stage_tb
`default_nettype wire

// ==== rtl/sis_core_stage.sv ====
// core event stage: edge latch, pending and active tracking
`timescale 1ns/1ps
`default_nettype none
module sis_core_stage #(
  parameter int unsigned NUM_EVT = sis_pkg::NUM_EVT
) (
  input  wire logic               clk_sys,
  input  wire logic               resetn,
  input  wire logic [NUM_EVT-1:0] event_in,
  input  wire logic [NUM_EVT-1:0] enter_ok,
  input  wire logic [NUM_EVT-1:0] event_done,
  output logic      [NUM_EVT-1:0] latched_q,
  output logic      [NUM_EVT-1:0] active_q
);
  logic [NUM_EVT-1:0] prev_q;
  logic [NUM_EVT-1:0] rise_q;
  logic [NUM_EVT-1:0] enter;
  logic [NUM_EVT-1:0] rise;
  assign rise  = event_in & ~prev_q;
  // entry needs a latched bit a cycle old, giving three cycles edge to active
  assign enter = latched_q & enter_ok & ~active_q;
  // edge detection is two cycles: sample, then register the edge
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prev_q <= '0;
      rise_q <= '0;
    end else begin
      prev_q <= event_in;
      rise_q <= rise;
    end
  end
  // set wins over clear so a new edge during entry is kept queued
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      latched_q <= '0;
      active_q  <= '0;
    end else begin
      latched_q <= (latched_q & ~enter) | rise_q;
      active_q  <= (active_q & ~event_done) | enter;
    end
  end
endmodule : sis_core_stage
`default_nettype wire

// ==== rtl/sis_pkg.sv ====
// constants shared by the system interrupt stage files
// Functional notes
// - three 32-bit control/status registers, one bit per peripheral event
// - mask bit set lets the event through; cleared bit blocks it
// - source status shows one for each peripheral asserting its request
// - wakeup enable bit lets that event wake an idled core
// - shared inputs may overlap; active-event register serves as acknowledgement
// - latched bit sets on rising edge; detection takes two core cycles
// - latched bit clears when matching active bit becomes set
// - once active, the next rising edge on that input is queued again
// - at least three cycles from rising edge to active output
// - active register kept by hardware, readable in supervisor mode only
// - control registers supervisor-only; peripherals see reserved space
package sis_pkg;
  localparam int unsigned NUM_SRC = 32;
  localparam int unsigned NUM_EVT = 9;
  localparam int unsigned ADDR_W  = 4;
  localparam logic [3:0] OFF_MASK   = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_WAKE   = 4'h8;
  localparam logic [3:0] OFF_ACTIVE = 4'hC;
  localparam logic [31:0] RST_MASK = 32'h0000_0000;
  localparam logic [31:0] RST_WAKE = 32'h0000_0000;
  localparam logic [31:0] READ_RESERVED = 32'h0000_0000;
  localparam logic [1:0]  MIN_PEND_CYCLES = 2'h1;
endpackage : sis_pkg

// ==== rtl/sis_system_stage.sv ====
// system event stage: mask, status, wakeup and mapping onto core events
`timescale 1ns/1ps
`default_nettype none
module sis_system_stage #(
  parameter int unsigned NUM_SRC = sis_pkg::NUM_SRC,
  parameter int unsigned NUM_EVT = sis_pkg::NUM_EVT,
  parameter logic [NUM_SRC*4-1:0] SRC_MAP = '0
) (
  input  wire logic                        clk_sys,
  input  wire logic                        resetn,
  input  wire logic [NUM_SRC-1:0]          periph_irq,
  input  wire logic                        core_idle,
  input  wire logic [NUM_EVT-1:0]          core_enter_ok,
  input  wire logic [NUM_EVT-1:0]          core_event_done,
  input  wire logic                        reg_sel,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_supervisor,
  input  wire logic [sis_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [31:0]                 reg_wdata,
  output logic      [31:0]                 reg_rdata,
  output logic      [NUM_EVT-1:0]          active_event_register,
  output logic      [NUM_EVT-1:0]          latched_event_register,
  output logic                             wake_core,
  output logic      [NUM_EVT-1:0]          shared_event
);
  // elaboration checks: status word is 32 bits and the map field is 4 bits wide
  if (NUM_SRC > 32 || NUM_SRC == 0) begin : g_bad_num_src
    $error("NUM_SRC must be 1..32");
  end
  if (NUM_EVT > 16 || NUM_EVT == 0) begin : g_bad_num_evt
    $error("NUM_EVT must be 1..16");
  end
  logic [31:0] mask_q;
  logic [31:0] wake_q;
  logic [31:0] status_q;
  logic [NUM_SRC-1:0] s1_q;
  logic [NUM_SRC-1:0] s2_q;
  logic [NUM_SRC-1:0] s3_q;
  logic [NUM_EVT-1:0] evt_d;
  logic [NUM_EVT-1:0] evt_q;
  logic [NUM_EVT-1:0] act_w;
  logic [NUM_EVT-1:0] lat_w;
  logic [31:0] masked_w;
  logic [31:0] rd_d;
  logic        wake_d;
  logic        acc_ok;
  logic        wr_mask;
  logic        wr_wake;

  // peripheral pins pass three flops; a change counts when stages two and three agree
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= periph_irq;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // only supervisor accesses decode; others read as reserved and write nothing
  assign acc_ok  = reg_sel & reg_supervisor;
  assign wr_mask = acc_ok & reg_wr & (reg_addr == sis_pkg::OFF_MASK);
  assign wr_wake = acc_ok & reg_wr & (reg_addr == sis_pkg::OFF_WAKE);
  assign masked_w = status_q & mask_q;
  assign wake_d   = core_idle & |(status_q & wake_q);

  // route each masked source onto its shared core input
  always_comb begin
    evt_d = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (masked_w[i]) evt_d[SRC_MAP[i*4 +: 4]] = 1'b1;
    end
  end

  // read decode; peripherals and unmapped offsets see reserved zeros
  always_comb begin
    rd_d = sis_pkg::READ_RESERVED;
    if (acc_ok && !reg_wr) begin
      unique case (reg_addr)
        sis_pkg::OFF_MASK:   rd_d = mask_q;
        sis_pkg::OFF_STATUS: rd_d = status_q;
        sis_pkg::OFF_WAKE:   rd_d = wake_q;
        sis_pkg::OFF_ACTIVE: rd_d = 32'(act_w);
        default:             rd_d = sis_pkg::READ_RESERVED;
      endcase
    end
  end

  // register file of three 32-bit words; status bits above NUM_SRC stay zero
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mask_q   <= sis_pkg::RST_MASK;
      wake_q   <= sis_pkg::RST_WAKE;
      status_q <= '0;
    end else begin
      if (wr_mask) mask_q <= reg_wdata;
      if (wr_wake) wake_q <= reg_wdata;
      status_q <= 32'({s3_q & s2_q} | (status_q[NUM_SRC-1:0] & (s3_q | s2_q)));
    end
  end

  // outputs straight from flops
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      evt_q                  <= '0;
      reg_rdata              <= '0;
      wake_core              <= 1'b0;
      active_event_register  <= '0;
      latched_event_register <= '0;
      shared_event           <= '0;
    end else begin
      evt_q                  <= evt_d;
      reg_rdata              <= rd_d;
      wake_core              <= wake_d;
      active_event_register  <= act_w;
      latched_event_register <= lat_w;
      shared_event           <= evt_d;
    end
  end

  sis_core_stage #(.NUM_EVT(NUM_EVT)) u_core (
    .clk_sys    (clk_sys),
    .resetn     (resetn),
    .event_in   (evt_q),
    .enter_ok   (core_enter_ok),
    .event_done (core_event_done),
    .latched_q  (lat_w),
    .active_q   (act_w)
  );
endmodule : sis_system_stage
`default_nettype wire
